/* rtl/smc_muting_controller.sv */
// Safeguard muting controller driving a redundant safety output pair.
//
// Overview of operation
// - Manual reset accepted after contact held 0.25 to 2 s, then released.
// - Auto reset with inputs satisfied: outputs on, green lit, dash shown.
// - Manual mode awaiting reset: yellow flashes and dash is displayed.
// - Stop input opening outside mute turns outputs off until it recloses.
// - Mute begins only when first sensor pair activates within 3 s.
// - Mute indicator is on while muted.
// - Main safeguard stop during mute drops its LEDs, keeps outputs and green.
// - Backdoor timer counts down on display when main opens muted; else dash flashes.
// - Sensors cleared and main closed before expiry ends mute, outputs stay on.
// - One-way muting refuses mute when second pair leads first pair.
// - With permit configured, mute may begin only while permit contact closed.
// - Permit opening during mute is ignored but must reclose before next mute.
// - Bypass switch makes mute always permitted.
// - Both switch banks off: one feedback channel monitored.
// - Disable off, channel count on: both feedback channels monitored.
// - Disable on: feedback monitoring skipped.
// - Green channel LEDs lit per channel, each while its own channel carries go.
// - Both safety outputs switch off together.
// - Channel mismatch outside the reset wait withholds reset until both channels open and close.
`timescale 1ns/1ps
`default_nettype none

module smc_muting_controller
   import smc_pkg::*;
#(
   parameter int unsigned RST_MIN   = RST_MIN_CYC,
   parameter int unsigned RST_MAX   = RST_MAX_CYC,
   parameter int unsigned MUTE_SKEW = MUTE_SKEW_CYC,
   parameter int unsigned SEC       = SEC_CYC,
   parameter int unsigned FB_TIME   = FEEDBACK_CYC,
   parameter int unsigned FLASH     = FLASH_CYC
) (
   // Clock and reset.
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   // Stop inputs, channel A and B (high means go).
   input  wire logic [1:0] main_safeguard_stop_input_i,
   input  wire logic [1:0] supplemental_stop_input_i,
   // Operator and machine contacts.
   input  wire logic       reset_contact_i,
   input  wire logic       mute_window_permit_i,
   input  wire logic       feedback_input_one_i,
   input  wire logic       feedback_input_two_i,
   input  wire logic       fault_clear_i,
   // Mute sensors.
   input  wire logic       mute_sensor_a1_i,
   input  wire logic       mute_sensor_a2_i,
   input  wire logic       mute_sensor_b1_i,
   input  wire logic       mute_sensor_b2_i,
   // Configuration.
   input  wire smc_cfg_t   cfg_i,
   // Outputs.
   output logic [1:0]      safety_output_pair_o,
   output smc_ind_t        ind_o,
   output logic            fault_o
);

   // ****************************************
   // Internal state.
   // ****************************************

   // All state of the module; one packed struct keeps the register and its next value in step.
   typedef struct packed {
      smc_st_t    st;
      logic [31:0] rst_cnt;
      logic        rst_seen;
      logic        armed_main;
      logic        armed_supp;
      logic [31:0] skew_cnt;
      logic        skew_run;
      logic        b_first;
      logic        permit_spent;
      logic [31:0] sec_cnt;
      logic [6:0]  bd_left;
      logic [31:0] fb_cnt;
      logic [31:0] fl_cnt;
      logic        fl;
      logic [1:0]  out;
      smc_ind_t    ind;
      logic        fault;
   } smc_state_t;

   smc_state_t s_q, s_d;

   // ****************************************
   // Input decoding.
   // ****************************************

   // Decodes both channels of an interface as go.
   function automatic logic both_go(input logic [1:0] ch);
      both_go = &ch;
   endfunction

   // Decodes a channel mismatch (one open, one closed).
   function automatic logic mismatch(input logic [1:0] ch);
      mismatch = ^ch;
   endfunction

   logic a_pair, b_pair, a_any, permit_ok, fb_ok;
   logic main_go, supp_go;

   // Input decoding.
   always_comb begin
      a_pair  = mute_sensor_a1_i & mute_sensor_a2_i;
      b_pair  = mute_sensor_b1_i & mute_sensor_b2_i;
      a_any   = mute_sensor_a1_i | mute_sensor_a2_i;
      main_go = both_go(main_safeguard_stop_input_i);
      supp_go = both_go(supplemental_stop_input_i);
      // A bypass or an unused permit treats muting as allowed.
      permit_ok = cfg_i.permit_bypass_switch | ~cfg_i.permit_used
                  | (mute_window_permit_i & ~s_q.permit_spent);
      // Feedback contacts are closed while the outputs are off.
      if (cfg_i.monitoring_disable_switch) begin
         fb_ok = 1'b1;
      end else if (cfg_i.channel_count_switch) begin
         fb_ok = feedback_input_one_i & feedback_input_two_i;
      end else begin
         fb_ok = feedback_input_one_i;
      end
   end

   // ****************************************
   // Next-state logic.
   // ****************************************

   // Next-state logic.
   always_comb begin
      // Every field defaults to its held value, so a branch that says nothing keeps it.
      s_d = s_q;
      // Flash timebase.
      if (s_q.fl_cnt >= FLASH - 1) begin
         s_d.fl_cnt = '0;
         s_d.fl     = ~s_q.fl;
      end else begin
         s_d.fl_cnt = s_q.fl_cnt + 32'd1;
      end
      // Re-arm an interface only after both channels were seen open, so a
      // stuck channel cannot be masked by a single-channel cycle.
      if (main_safeguard_stop_input_i == 2'b00) begin
         s_d.armed_main = 1'b1;
      end
      if (supplemental_stop_input_i == 2'b00) begin
         s_d.armed_supp = 1'b1;
      end
      // Permit must reclose before another mute.
      if (!mute_window_permit_i) begin
         s_d.permit_spent = 1'b0;
      end
      // Sensor pair skew window. The counter saturates at the limit, so a pair
      // that stays half-active for a long time can never wrap back into the window.
      if (!a_pair && !a_any && !b_pair) begin
         s_d.skew_run = 1'b0;
         s_d.skew_cnt = '0;
         s_d.b_first  = 1'b0;
      end else begin
         if (b_pair && !a_any) begin
            s_d.b_first = 1'b1;
         end
         if (a_any && !s_q.skew_run) begin
            s_d.skew_run = 1'b1;
         end
         if (s_q.skew_run && s_q.skew_cnt < MUTE_SKEW) begin
            s_d.skew_cnt = s_q.skew_cnt + 32'd1;
         end
      end
      // Reset contact hold timer.
      s_d.rst_seen = 1'b0;
      if (reset_contact_i) begin
         if (s_q.rst_cnt <= RST_MAX) begin
            s_d.rst_cnt = s_q.rst_cnt + 32'd1;
         end
      end else begin
         s_d.rst_cnt  = '0;
         s_d.rst_seen = (s_q.rst_cnt >= RST_MIN) && (s_q.rst_cnt <= RST_MAX);
      end
      // Feedback check: outputs off must see contacts closed in time.
      if (s_q.out == 2'b00 && !fb_ok) begin
         s_d.fb_cnt = s_q.fb_cnt + 32'd1;
      end else begin
         s_d.fb_cnt = '0;
      end

      // Main sequence.
      case (s_q.st)
         SMC_ST_STOP: begin
            s_d.out = 2'b00;
            if (main_go && supp_go && s_q.armed_main && s_q.armed_supp && fb_ok) begin
               s_d.st = cfg_i.manual_reset ? SMC_ST_WAIT : SMC_ST_RUN;
            end
         end
         SMC_ST_WAIT: begin
            s_d.out = 2'b00;
            if (!(main_go && supp_go)) begin
               s_d.st = SMC_ST_STOP;
            end else if (s_q.rst_seen) begin
               s_d.st = SMC_ST_RUN;
            end
         end
         SMC_ST_RUN: begin
            s_d.out = 2'b11;
            if (!main_go || !supp_go) begin
               s_d.out = 2'b00;
               s_d.st  = SMC_ST_STOP;
               if (!main_go) s_d.armed_main = 1'b0;
               if (!supp_go) s_d.armed_supp = 1'b0;
            end else if (a_pair && s_q.skew_cnt < MUTE_SKEW && permit_ok
                         && !(cfg_i.one_way && s_q.b_first)) begin
               s_d.st           = SMC_ST_MUTE;
               s_d.permit_spent = cfg_i.permit_used;
               s_d.sec_cnt      = '0;
               s_d.bd_left      = (cfg_i.backdoor == SMC_BD_60) ? 7'(BD_LONG_S) : 7'(BD_SHORT_S);
            end
         end
         SMC_ST_MUTE: begin
            // Main safeguard stop is suspended; supplemental stop is not, so a
            // person entering beside the muted object still stops the machine.
            s_d.out = 2'b11;
            if (s_q.sec_cnt >= SEC - 1) begin
               s_d.sec_cnt = '0;
               if (s_q.bd_left != 7'd0) s_d.bd_left = s_q.bd_left - 7'd1;
            end else begin
               s_d.sec_cnt = s_q.sec_cnt + 32'd1;
            end
            if (!supp_go) begin
               s_d.out = 2'b00;
               s_d.st  = SMC_ST_STOP;
               s_d.armed_supp = 1'b0;
            end else if (cfg_i.backdoor != SMC_BD_OFF && s_q.bd_left == 7'd0) begin
               s_d.out = 2'b00;
               s_d.st  = SMC_ST_STOP;
               s_d.armed_main = main_go ? s_q.armed_main : 1'b0;
            end else if (!a_pair && !b_pair && main_go) begin
               s_d.st = SMC_ST_RUN;
            end
         end
         SMC_ST_FAULT: begin
            s_d.out = 2'b00;
            if (fault_clear_i) s_d.st = SMC_ST_STOP;
         end
         default: begin
            s_d.st  = SMC_ST_FAULT;
            s_d.out = 2'b00;
         end
      endcase

      // Feedback failure forces the fault state; a channel mismatch alone does not.
      // The fault state is left only through the clear input, never by itself.
      if (s_q.fb_cnt >= FB_TIME
          || mismatch(main_safeguard_stop_input_i) && s_q.st != SMC_ST_MUTE && s_q.fb_cnt >= FB_TIME) begin
         s_d.st  = SMC_ST_FAULT;
         s_d.out = 2'b00;
      end
      s_d.fault = (s_d.st == SMC_ST_FAULT);

      // Indicators.
      s_d.ind.main_ch_led = main_safeguard_stop_input_i;
      s_d.ind.supp_ch_led = supplemental_stop_input_i;
      s_d.ind.green       = (s_d.out == 2'b11);
      s_d.ind.yellow      = (s_d.st == SMC_ST_WAIT) & s_q.fl;
      s_d.ind.red         = s_d.fault & s_q.fl;
      s_d.ind.mute_lamp   = (s_d.st == SMC_ST_MUTE);
      if (s_d.fault) begin
         s_d.ind.display = DISP_ERR;
      end else if (s_d.st == SMC_ST_MUTE && !main_go) begin
         if (cfg_i.backdoor != SMC_BD_OFF) begin
            s_d.ind.display = {1'b0, s_d.bd_left};
         end else begin
            s_d.ind.display = s_q.fl ? DISP_DASH : DISP_BLANK;
         end
      end else begin
         s_d.ind.display = DISP_DASH;
      end
   end

   // ****************************************
   // State register and outputs.
   // ****************************************

   // State register; outputs start off and both interfaces armed after power-on.
   // Starting armed lets a power-up with go inputs run without a stop cycle first.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_q             <= '0;
         s_q.st          <= SMC_ST_STOP;
         s_q.armed_main  <= 1'b1;
         s_q.armed_supp  <= 1'b1;
         s_q.ind.display <= DISP_DASH;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from flip-flops.
   assign safety_output_pair_o = s_q.out;
   assign ind_o                = s_q.ind;
   assign fault_o              = s_q.fault;

endmodule

`default_nettype wire

/* rtl/smc_pkg.sv */
// Package of constants and types for the safeguard muting controller.
package smc_pkg;

   // Clock rate and timing constants.
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned RST_MIN_MS      = 250;
   localparam int unsigned RST_MAX_MS      = 2000;
   localparam int unsigned MUTE_SKEW_MS    = 3000;
   localparam int unsigned BD_SHORT_S      = 30;
   localparam int unsigned BD_LONG_S       = 60;
   localparam int unsigned FEEDBACK_MS     = 100;
   localparam int unsigned FLASH_MS        = 250;
   localparam int unsigned MS_CYC          = CLK_HZ / 1000;
   localparam int unsigned RST_MIN_CYC     = (RST_MIN_MS * MS_CYC);
   localparam int unsigned RST_MAX_CYC     = (RST_MAX_MS * MS_CYC);
   localparam int unsigned MUTE_SKEW_CYC   = (MUTE_SKEW_MS * MS_CYC);
   localparam int unsigned SEC_CYC         = CLK_HZ;
   localparam int unsigned FEEDBACK_CYC    = (FEEDBACK_MS * MS_CYC);
   localparam int unsigned FLASH_CYC       = (FLASH_MS * MS_CYC);

   // Display codes.
   localparam logic [7:0] DISP_DASH  = 8'hF0;
   localparam logic [7:0] DISP_BLANK = 8'hFF;
   localparam logic [7:0] DISP_ERR   = 8'hE1;

   // Backdoor timer selection.
   typedef enum logic [1:0] {SMC_BD_OFF, SMC_BD_30, SMC_BD_60} smc_bd_t;

   // Top-level state.
   typedef enum logic [2:0] {SMC_ST_STOP, SMC_ST_WAIT, SMC_ST_RUN, SMC_ST_MUTE, SMC_ST_FAULT} smc_st_t;

   // Configuration switches.
   typedef struct packed {
      logic    manual_reset;
      logic    one_way;
      logic    permit_used;
      logic    permit_bypass_switch;
      logic    monitoring_disable_switch;
      logic    channel_count_switch;
      smc_bd_t backdoor;
   } smc_cfg_t;

   // Indicator outputs.
   typedef struct packed {
      logic       green;
      logic       yellow;
      logic       red;
      logic       mute_lamp;
      logic [1:0] main_ch_led;
      logic [1:0] supp_ch_led;
      logic [7:0] display;
   } smc_ind_t;

endpackage

/* bench/smc_checker.sv */
// Assertion checker bound to the safeguard muting controller ports.
`timescale 1ns/1ps
`default_nettype none
module smc_checker
   import smc_pkg::*;
#(
   parameter int unsigned RST_MIN = 10, RST_MAX = 50, MUTE_SKEW = 30,
   parameter int unsigned SEC     = 20, FB_TIME = 8,  FLASH     = 4
) (
   // Clock and reset.
   input wire logic       clk_i,
   input wire logic       rstn_i,
   // Watched inputs.
   input wire logic [1:0] main_safeguard_stop_input_i,
   input wire logic [1:0] supplemental_stop_input_i,
   input wire logic       reset_contact_i,
   input wire logic       mute_sensor_a1_i,
   input wire logic       mute_sensor_a2_i,
   input wire smc_cfg_t   cfg_i,
   // Watched outputs.
   input wire logic [1:0] safety_output_pair_o,
   input wire smc_ind_t   ind_o,
   input wire logic       fault_o
);
   // Short aliases keep the properties readable.
   wire logic [1:0] so = safety_output_pair_o;
   wire logic [1:0] ms = main_safeguard_stop_input_i;
   wire logic [1:0] ss = supplemental_stop_input_i;
   wire logic       ml = ind_o.mute_lamp;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   // ****************************************
   // Assertions.
   // ****************************************
   // A split pair would leave one channel driving the machine, so any split is reported as an error.
   pair_equal_a: assert property (so inside {2'b00, 2'b11})
      else $error("outputs split");
   fault_hold_a: assert property (
      fault_o && $past(fault_o) |-> so == 2'b00 && ind_o.display == DISP_ERR)
      else $error("fault not held");
   green_out_a: assert property (so == 2'b11 |-> ind_o.green)
      else $error("green not lit");
   mute_start_a: assert property (
      $rose(ml) |-> $past(mute_sensor_a1_i && mute_sensor_a2_i) || $past(mute_sensor_a1_i && mute_sensor_a2_i, 2))
      else $error("mute without sensors");
   led_go_a: assert property ((ms == 2'b11) [*3] |-> ind_o.main_ch_led == 2'b11)
      else $error("channel leds dark");
   stop_off_a: assert property (
      (ms != 2'b11 || ss != 2'b11) && !ml && !$past(ml) |-> ##[1:3] so == 2'b00)
      else $error("stop ignored");
   mute_keep_a: assert property (
      ml && $past(ml) && so == 2'b11 && ss == 2'b11 |=> so == 2'b11 || !ml)
      else $error("mute dropped outputs");
   manual_rise_a: assert property (
      $rose(so[0]) && cfg_i.manual_reset |-> $past(reset_contact_i, 4) && !$past(reset_contact_i, 3))
      else $error("rise without reset");
   lamp_hold_a: assert property (ml && so == 2'b11 && $past(ml) |-> !fault_o)
      else $error("lamp during fault");
   // ****************************************
   // Cover points.
   // ****************************************
   // Main scenarios reached.
   mute_c: cover property ($rose(ml));
   fault_c: cover property ($rose(fault_o));
   manual_c: cover property ($rose(so[0]) && cfg_i.manual_reset);
endmodule
bind smc_muting_controller smc_checker #(.RST_MIN(RST_MIN), .RST_MAX(RST_MAX), .MUTE_SKEW(MUTE_SKEW),
   .SEC(SEC), .FB_TIME(FB_TIME), .FLASH(FLASH)) u_chk (.clk_i, .rstn_i, .main_safeguard_stop_input_i,
   .supplemental_stop_input_i, .reset_contact_i, .mute_sensor_a1_i, .mute_sensor_a2_i, .cfg_i,
   .safety_output_pair_o, .ind_o, .fault_o);
`default_nettype wire

/* bench/smc_contactor_model.sv */
// Model of the machine contactors whose contacts feed back to the controller.
`timescale 1ns/1ps
`default_nettype none
module smc_contactor_model
   import smc_pkg::*;
(
   // Safety outputs and configuration.
   input  wire logic [1:0] outs_i,
   input  wire smc_cfg_t   cfg_i,
   // Forced stuck-open contact, one bit per channel.
   input  wire logic [1:0] stuck_i,
   // Feedback contacts, high means closed.
   output wire logic       fb1_o,
   output wire logic       fb2_o
);
   // ****************************************
   // Contact behaviour.
   // ****************************************
   // Contacts close while released; unused inputs are left open, which reads low.
   assign fb1_o = !outs_i[0] && !stuck_i[0] && !cfg_i.monitoring_disable_switch;
   assign fb2_o = !outs_i[1] && !stuck_i[1] && cfg_i.channel_count_switch
                  && !cfg_i.monitoring_disable_switch;
endmodule
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking testbench for the safeguard muting controller.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import smc_pkg::*;
   // ****************************************
   // Stimulus, observed outputs and counters.
   // ****************************************
   logic        clk_i = 1'b0, rstn_i = 1'b0, rc = 1'b0, pm = 1'b0, fc = 1'b0, flt, fb1, fb2;
   logic        a1 = 1'b0, a2 = 1'b0, b1 = 1'b0, b2 = 1'b0;
   logic [1:0]  ms = 2'b11, ss = 2'b11, outs, stuck = 2'b00;
   logic [31:0] seed = 32'h823e_8a84;
   smc_cfg_t    cfg = '0;
   smc_ind_t    ind;
   int          error_cnt = 0, n_compared = 0, y, r, len[3];

   // Clock of 40 ns period.
   always #20 clk_i = ~clk_i;

   // Short counts keep the run brief; the shortest reset hold is scaled down from its package figure.
   smc_muting_controller #(.RST_MIN(RST_MIN_MS / 25), .RST_MAX(50), .MUTE_SKEW(30), .SEC(20), .FB_TIME(8),
      .FLASH(4)) dut (
      .clk_i(clk_i), .rstn_i(rstn_i), .main_safeguard_stop_input_i(ms), .supplemental_stop_input_i(ss),
      .reset_contact_i(rc), .mute_window_permit_i(pm), .feedback_input_one_i(fb1), .feedback_input_two_i(fb2),
      .fault_clear_i(fc), .mute_sensor_a1_i(a1), .mute_sensor_a2_i(a2), .mute_sensor_b1_i(b1),
      .mute_sensor_b2_i(b2), .cfg_i(cfg), .safety_output_pair_o(outs), .ind_o(ind), .fault_o(flt));
   smc_contactor_model fbm (.outs_i(outs), .cfg_i(cfg), .stuck_i(stuck), .fb1_o(fb1), .fb2_o(fb2));

   // ****************************************
   // Helpers.
   // ****************************************
   // Xorshift source; the fixed seed keeps runs repeatable.
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic int bd_secs(smc_bd_t b);
      return (b == SMC_BD_60) ? BD_LONG_S : BD_SHORT_S;
   endfunction
   task automatic cyc(int n);
      repeat (n) @(negedge clk_i);
   endtask
   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic pulse(int n);
      rc = 1'b1;
      cyc(n);
      rc = 1'b0;
      cyc(4);
   endtask
   task automatic mute(int n);
      a1 = 1'b1;
      cyc(n);
      a2 = 1'b1;
      cyc(3);
   endtask
   // Counts lit cycles over more than one flash period, so a steady lamp shows as 0 or 10.
   task automatic blink();
      y = 0;
      r = 0;
      repeat (10) begin
         cyc(1);
         y += int'(ind.yellow);
         r += int'(ind.red);
      end
   endtask
   task automatic summarize();
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog far beyond the expected run of under two thousand cycles.
   initial begin
      repeat (20000) @(posedge clk_i);
      error_cnt++;
      summarize();
   end

   // ****************************************
   // Scenarios.
   // ****************************************
   initial begin
      cyc(10);
      rstn_i = 1'b1;
      cyc(4);
      chk("outs", 8'h03, 8'(outs));
      chk("display", DISP_DASH, ind.display);
      chk("leds", 8'h0f, 8'({ind.main_ch_led, ind.supp_ch_led}));
      ss = 2'b00;
      cyc(3);
      chk("outs", 8'h00, 8'(outs));
      ss = 2'b11;
      cyc(3);
      chk("outs", 8'h03, 8'(outs));
      // Only channel A opens, so reclosing alone must not rearm.
      ms = 2'b10;
      cyc(3);
      ms = 2'b11;
      cyc(3);
      chk("outs", 8'h00, 8'(outs));
      ms = 2'b00;
      cyc(3);
      ms = 2'b11;
      cyc(3);
      chk("outs", 8'h03, 8'(outs));
      // Manual mode: short, long and in-window reset pulses.
      cfg.manual_reset = 1'b1;
      ms = 2'b00;
      cyc(3);
      ms = 2'b11;
      blink();
      chk("yellow_flash", 8'h01, 8'(y > 0 && y < 10));
      chk("display", DISP_DASH, ind.display);
      len = '{5, 60, 12 + int'(xs() % 36)};
      for (int i = 0; i < 3; i++) begin
         pulse(len[i]);
         chk("outs", (i == 2) ? 8'h03 : 8'h00, 8'(outs));
      end
      // Mute, main stop during mute with countdown, then clean end.
      cfg.backdoor = SMC_BD_30;
      mute(int'(xs() % 25));
      chk("mute_lamp", 8'h01, 8'(ind.mute_lamp));
      ms = 2'b00;
      cyc(3);
      chk("outs_green", 8'h07, 8'({ind.green, outs}));
      chk("main_led", 8'h00, 8'(ind.main_ch_led));
      chk("countdown", 8'h01, 8'(ind.display >= 1 && ind.display <= bd_secs(cfg.backdoor)));
      ms = 2'b11;
      cyc(3);
      {a1, a2} = 2'b00;
      cyc(3);
      chk("lamp_outs", 8'h03, 8'({ind.mute_lamp, outs}));
      // Without a backdoor timer the display flashes a dash while main is open.
      cfg.backdoor = SMC_BD_OFF;
      mute(1);
      ms = 2'b00;
      cyc(3);
      y = int'(ind.display);
      cyc(4);
      chk("dash_flash", DISP_DASH ^ DISP_BLANK, ind.display ^ 8'(y));
      ms = 2'b11;
      {a1, a2} = 2'b00;
      cyc(3);
      chk("lamp_outs", 8'h03, 8'({ind.mute_lamp, outs}));
      cfg.backdoor = SMC_BD_60;
      // Skew too wide, one-way reversed, permit open, permit bypassed.
      for (int i = 0; i < 4; i++) begin
         cfg.one_way = (i == 1);
         cfg.permit_used = (i >= 2);
         cfg.permit_bypass_switch = (i == 3);
         {b1, b2} = {2{i == 1}};
         cyc(2);
         mute((i == 0) ? 40 : 1);
         chk("mute_lamp", 8'(i == 3), 8'(ind.mute_lamp));
         {a1, a2, b1, b2} = 4'h0;
         cyc(5);
      end
      // Permit opening mid-mute is ignored but must reclose before the next mute.
      cfg.permit_bypass_switch = 1'b0;
      pm = 1'b1;
      mute(2);
      pm = 1'b0;
      cyc(3);
      chk("mute_lamp", 8'h01, 8'(ind.mute_lamp));
      {a1, a2} = 2'b00;
      cyc(4);
      mute(2);
      chk("mute_lamp", 8'h00, 8'(ind.mute_lamp));
      {a1, a2} = 2'b00;
      pm = 1'b1;
      cyc(2);
      mute(2);
      chk("mute_lamp", 8'h01, 8'(ind.mute_lamp));
      // Permit held closed across a mute is spent; it must open and reclose first.
      {a1, a2} = 2'b00;
      cyc(4);
      mute(2);
      chk("mute_lamp", 8'h00, 8'(ind.mute_lamp));
      {a1, a2} = 2'b00;
      pm = 1'b0;
      cyc(2);
      pm = 1'b1;
      cyc(2);
      mute(2);
      chk("mute_lamp", 8'h01, 8'(ind.mute_lamp));
      // Backdoor expiry with main still stopped.
      ms = 2'b00;
      cyc(bd_secs(cfg.backdoor) * 20 + 20);
      chk("lamp_outs", 8'h00, 8'({ind.mute_lamp, outs}));
      ms = 2'b11;
      {a1, a2} = 2'b00;
      cyc(3);
      pulse(20);
      // Feedback stuck open in one-channel, two-channel and unmonitored setups.
      for (int i = 0; i < 3; i++) begin
         cfg.monitoring_disable_switch = (i == 2);
         cfg.channel_count_switch = (i == 1);
         stuck = (i == 0) ? 2'b01 : (i == 1) ? 2'b10 : 2'b11;
         ss = 2'b00;
         cyc(20);
         blink();
         chk("fault", 8'(i < 2), 8'(flt));
         chk("outs", 8'h00, 8'(outs));
         if (i < 2) begin
            chk("display", DISP_ERR, ind.display);
            chk("red_flash", 8'h01, 8'(r > 0 && r < 10));
         end
         stuck = 2'b00;
         ss = 2'b11;
         fc = 1'b1;
         cyc(2);
         fc = 1'b0;
         cyc(2);
         pulse(20);
         chk("outs", 8'h03, 8'(outs));
      end
      summarize();
   end
endmodule
`default_nettype wire
